// file: hdl/eoa_alu.sv
`timescale 1ns/1ps
`include "eoa_params.svh"
module eoa_alu (
    input  wire eoa_pkg::eoa_op_t    op_i,
    input  wire logic [7:0]          acc_i,
    input  wire logic [7:0]          mem_i,
    input  wire logic [2:0]          bit_i,
    input  wire eoa_pkg::eoa_flags_t flags_i,
    output eoa_pkg::eoa_alu_out_t    out_o
);
    logic [8:0] diff;
    logic [4:0] ldiff;
    logic [7:0] adj;
    logic [8:0] dsum;
    logic [7:0] bmask;
    logic [7:0] dec;
    logic [7:0] inc;
    logic       borrow;

    // Shared arithmetic, computed once for all operations
    assign borrow = ~flags_i.c;
    assign diff   = {1'b0, acc_i} - {1'b0, mem_i} - {8'h00, borrow};
    assign ldiff  = {1'b0, acc_i[3:0]} - {1'b0, mem_i[3:0]} - {4'h0, borrow};
    assign adj    = (((acc_i[3:0] > `EOA_NIB_MAX) | flags_i.ac) ? `EOA_BCD_LO : `EOA_BYTE_ZERO)
                  | (((acc_i[7:4] > `EOA_NIB_MAX) | flags_i.c) ? `EOA_BCD_HI : `EOA_BYTE_ZERO);
    assign dsum   = {1'b0, acc_i} + {1'b0, adj};
    assign bmask  = `EOA_BYTE_ONE << bit_i;
    assign dec    = mem_i - `EOA_BYTE_ONE;
    assign inc    = mem_i + `EOA_BYTE_ONE;

    // Result select; one write flag, steered to acc or memory by the variant
    always_comb begin
        logic wr;
        logic to_acc;
        wr          = 1'b1;
        to_acc      = 1'b0;
        out_o       = '0;
        out_o.flags = flags_i;
        case (op_i)
            eoa_pkg::decimal_adjust_to_mem: begin
                out_o.res     = dsum[7:0];
                out_o.flags.c = flags_i.c | dsum[8];
            end
            eoa_pkg::ext_decrement_mem, eoa_pkg::ext_decrement_to_acc: begin
                out_o.res     = dec;
                out_o.flags.z = (dec == `EOA_BYTE_ZERO);
                to_acc        = (op_i == eoa_pkg::ext_decrement_to_acc);
            end
            eoa_pkg::ext_increment_mem, eoa_pkg::ext_increment_to_acc: begin
                out_o.res     = inc;
                out_o.flags.z = (inc == `EOA_BYTE_ZERO);
                to_acc        = (op_i == eoa_pkg::ext_increment_to_acc);
            end
            eoa_pkg::ext_move: begin
                out_o.res = mem_i;
                to_acc    = 1'b1;
            end
            eoa_pkg::ext_move_to_mem: out_o.res = acc_i;
            eoa_pkg::ext_or_to_acc, eoa_pkg::ext_or_to_mem: begin
                out_o.res     = acc_i | mem_i;
                out_o.flags.z = ((acc_i | mem_i) == `EOA_BYTE_ZERO);
                to_acc        = (op_i == eoa_pkg::ext_or_to_acc);
            end
            eoa_pkg::ext_rotate_left, eoa_pkg::ext_rotate_left_to_acc: begin
                out_o.res = {mem_i[6:0], mem_i[7]};
                to_acc    = (op_i == eoa_pkg::ext_rotate_left_to_acc);
            end
            eoa_pkg::ext_rotate_right, eoa_pkg::ext_rotate_right_to_acc: begin
                out_o.res = {mem_i[0], mem_i[7:1]};
                to_acc    = (op_i == eoa_pkg::ext_rotate_right_to_acc);
            end
            eoa_pkg::ext_rotate_left_carry, eoa_pkg::ext_rotate_left_carry_to_acc: begin
                out_o.res     = {mem_i[6:0], flags_i.c};
                out_o.flags.c = mem_i[7];
                to_acc        = (op_i == eoa_pkg::ext_rotate_left_carry_to_acc);
            end
            eoa_pkg::ext_rotate_right_carry, eoa_pkg::ext_rotate_right_carry_to_acc: begin
                out_o.res     = {flags_i.c, mem_i[7:1]};
                out_o.flags.c = mem_i[0];
                to_acc        = (op_i == eoa_pkg::ext_rotate_right_carry_to_acc);
            end
            eoa_pkg::ext_sub_borrow_to_acc, eoa_pkg::ext_sub_borrow_to_mem: begin
                out_o.res      = diff[7:0];
                out_o.flags.c  = ~diff[8];
                out_o.flags.ac = ~ldiff[4];
                out_o.flags.ov = (acc_i[7] ^ mem_i[7]) & (acc_i[7] ^ diff[7]);
                out_o.flags.z  = (diff[7:0] == `EOA_BYTE_ZERO);
                out_o.flags.sc = diff[7] ^ out_o.flags.ov;
                out_o.flags.cz = out_o.flags.z & flags_i.cz;   // Chains multi-byte zero
                to_acc         = (op_i == eoa_pkg::ext_sub_borrow_to_acc);
            end
            eoa_pkg::ext_dec_skip_zero, eoa_pkg::ext_dec_skip_zero_to_acc: begin
                out_o.res  = dec;
                out_o.skip = (dec == `EOA_BYTE_ZERO);
                to_acc     = (op_i == eoa_pkg::ext_dec_skip_zero_to_acc);
            end
            eoa_pkg::ext_inc_skip_zero, eoa_pkg::ext_inc_skip_zero_to_acc: begin
                out_o.res  = inc;
                out_o.skip = (inc == `EOA_BYTE_ZERO);
                to_acc     = (op_i == eoa_pkg::ext_inc_skip_zero_to_acc);
            end
            eoa_pkg::ext_set_mem: out_o.res = `EOA_BYTE_ONES;
            eoa_pkg::ext_set_bit: out_o.res = mem_i | bmask;
            eoa_pkg::ext_skip_nonzero: begin
                out_o.res  = mem_i;
                out_o.skip = (mem_i != `EOA_BYTE_ZERO);
            end
            eoa_pkg::ext_skip_bit_nonzero: begin
                wr         = 1'b0;
                out_o.skip = ((mem_i & bmask) != `EOA_BYTE_ZERO);
            end
            default: wr = 1'b0;                                // Unused codes do nothing
        endcase
        out_o.wr_acc = wr & to_acc;
        out_o.wr_mem = wr & ~to_acc;
    end
endmodule

// file: hdl/eoa_params.svh
`ifndef EOA_PARAMS_SVH
`define EOA_PARAMS_SVH
// What this block does
// - Decimal adjust adds 06/60/66 to accumulator into memory; only carry changes.
// - Operand byte anywhere in the whole data memory, addressed directly.
// - Decrement memory byte, or put result in accumulator; zero flag updated.
// - Increment memory byte, or put result in accumulator; zero flag updated.
// - Move memory to accumulator or accumulator to memory; no flag changes.
// - OR accumulator with memory byte into accumulator or memory; zero flag updated.
// - Rotate left, bit 7 into bit 0, to memory or accumulator; no flags.
// - Rotate right, bit 0 into bit 7, to memory or accumulator; no flags.
// - Rotate left through carry; only carry changes.
// - Rotate right through carry; only carry changes.
// - Subtract with borrow: acc minus mem minus inverted carry, to acc or mem.
// - Borrow clears carry, else set; OV, Z, AC, SC, CZ also updated.
// - Decrement-and-skip writes memory, skips when result is zero, no flags.
// - Accumulator skip variants keep memory and skip when the result is zero.
// - Increment-and-skip writes memory, skips when result is zero, no flags.
// - Taken skip inserts a dummy cycle: three instruction cycles in all.
// - Byte set writes all ones; bit set forces one bit; no flags.
// - Bit test skips when the selected bit is one; flags unchanged.
// - Byte skip-if-nonzero writes the byte back and skips when nonzero.
`define EOA_OFF_CMD     8'h00
`define EOA_OFF_ADDR    8'h04
`define EOA_OFF_ACC     8'h08
`define EOA_OFF_FLAGS   8'h0c
`define EOA_OFF_MEMDAT  8'h10
`define EOA_OFF_INFO    8'h14
`define EOA_MEM_DEPTH   2048
`define EOA_CMD_OP_MSB  4
`define EOA_CMD_BIT_LSB 8
`define EOA_CMD_BIT_MSB 10
`define EOA_INFO_BUSY   0
`define EOA_INFO_SKIP   1
`define EOA_INFO_CYC_LSB 2
`define EOA_INFO_CYC_MSB 3
`define EOA_ACC_RST     8'h00
`define EOA_FLAGS_RST   6'h00
`define EOA_ADDR_RST    11'h000
`define EOA_CYC_RST     2'h0
`define EOA_CYC_PLAIN   2'h2
`define EOA_CYC_SKIP    2'h3
`define EOA_BCD_LO      8'h06
`define EOA_BCD_HI      8'h60
`define EOA_NIB_MAX     4'h9
`define EOA_BYTE_ONES   8'hff
`define EOA_BYTE_ONE    8'h01
`define EOA_BYTE_ZERO   8'h00
`define EOA_RD_ZERO     32'h0000_0000
`endif

// file: hdl/eoa_pkg.sv
package eoa_pkg;
    // Operation codes, numbered in this order from zero in the command register
    typedef enum logic [4:0] {
        decimal_adjust_to_mem, ext_decrement_mem, ext_decrement_to_acc,
        ext_increment_mem, ext_increment_to_acc, ext_move, ext_move_to_mem,
        ext_or_to_acc, ext_or_to_mem, ext_rotate_left, ext_rotate_left_to_acc,
        ext_rotate_left_carry, ext_rotate_left_carry_to_acc, ext_rotate_right,
        ext_rotate_right_to_acc, ext_rotate_right_carry, ext_rotate_right_carry_to_acc,
        ext_sub_borrow_to_acc, ext_sub_borrow_to_mem, ext_dec_skip_zero,
        ext_dec_skip_zero_to_acc, ext_set_mem, ext_set_bit, ext_inc_skip_zero,
        ext_inc_skip_zero_to_acc, ext_skip_nonzero, ext_skip_bit_nonzero
    } eoa_op_t;

    typedef enum logic [1:0] {st_idle, st_fetch, st_exec, st_dummy} eoa_state_t;

    // Status flags, carry in bit 0
    typedef struct packed {
        logic cz;
        logic sc;
        logic ov;
        logic z;
        logic ac;
        logic c;
    } eoa_flags_t;

    typedef struct packed {
        logic [7:0]          res;
        logic                wr_mem;
        logic                wr_acc;
        logic                skip;
        eoa_pkg::eoa_flags_t flags;
    } eoa_alu_out_t;
endpackage

// file: hdl/eoa_top.sv
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "eoa_params.svh"
module eoa_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             busy_o,
    output logic             skip_o,
    output logic             done_o
);
    // Data memory, byte wide, addressed over its full range
    logic [7:0] mem [`EOA_MEM_DEPTH];

    eoa_pkg::eoa_state_t   state;
    eoa_pkg::eoa_state_t   next_state;
    eoa_pkg::eoa_op_t      op;
    eoa_pkg::eoa_op_t      next_op;
    eoa_pkg::eoa_flags_t   flags;
    eoa_pkg::eoa_flags_t   next_flags;
    eoa_pkg::eoa_alu_out_t alu;
    logic [10:0]           addr;
    logic [10:0]           next_addr;
    logic [10:0]           op_addr;
    logic [10:0]           next_op_addr;
    logic [2:0]            bitsel;
    logic [2:0]            next_bitsel;
    logic [7:0]            acc;
    logic [7:0]            next_acc;
    logic [1:0]            cycles;
    logic [1:0]            next_cycles;
    logic                  skip;
    logic                  next_skip;
    logic                  done;
    logic                  next_done;
    logic                  busy;
    logic                  next_busy;
    logic                  ack;
    logic                  next_ack;
    logic [31:0]           dat;
    logic [31:0]           next_dat;
    logic [31:0]           rdval;
    logic [31:0]           wmerge;
    logic [7:0]            mem_rd;
    logic                  mem_we;
    logic [10:0]           mem_wa;
    logic [7:0]            mem_wd;
    logic                  req;
    logic                  wr_commit;
    logic                  start;
    logic [8:0]            sbc_need;

    assign wb_dat_o = dat;
    assign wb_ack_o = ack;
    assign busy_o   = busy;
    assign skip_o   = skip;
    assign done_o   = done;

    // Bus handshake terms; a write lands on the edge that sees ack high
    assign req       = wb_cyc_i & wb_stb_i;
    assign wr_commit = req & wb_we_i & ack & (state == eoa_pkg::st_idle);
    assign start     = wr_commit & (wb_adr_i == `EOA_OFF_CMD);
    assign mem_rd    = mem[op_addr];
    assign sbc_need  = {1'b0, mem_rd} + {8'h00, ~flags.c};

    // Read view of the addressed register; unmapped words read zero
    always_comb begin
        rdval = `EOA_RD_ZERO;
        case (wb_adr_i)
            `EOA_OFF_CMD: begin
                rdval[`EOA_CMD_OP_MSB:0]                = op;
                rdval[`EOA_CMD_BIT_MSB:`EOA_CMD_BIT_LSB] = bitsel;
            end
            `EOA_OFF_ADDR:   rdval[10:0] = addr;
            `EOA_OFF_ACC:    rdval[7:0]  = acc;
            `EOA_OFF_FLAGS:  rdval[5:0]  = flags;
            `EOA_OFF_MEMDAT: rdval[7:0]  = mem[addr];
            `EOA_OFF_INFO: begin
                rdval[`EOA_INFO_BUSY]                      = busy;
                rdval[`EOA_INFO_SKIP]                      = skip;
                rdval[`EOA_INFO_CYC_MSB:`EOA_INFO_CYC_LSB] = cycles;
            end
            default: rdval = `EOA_RD_ZERO;
        endcase
    end

    // Byte lanes: unselected lanes keep the current register contents
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign wmerge[lane*8 +: 8] = wb_sel_i[lane] ? wb_dat_i[lane*8 +: 8]
                                                        : rdval[lane*8 +: 8];
        end
    endgenerate

    eoa_alu u_alu (
        .op_i    (op),
        .acc_i   (acc),
        .mem_i   (mem_rd),
        .bit_i   (bitsel),
        .flags_i (flags),
        .out_o   (alu)
    );

    // Bus slave: one wait state, read data latched with ack
    always_comb begin
        next_ack = req & ~ack;
        next_dat = dat;
        if (req & ~ack) begin
            next_dat = rdval;
        end
    end

    // Sequencer and programmer-visible state; writes are ignored while busy
    always_comb begin
        next_state   = state;
        next_op      = op;
        next_op_addr = op_addr;
        next_bitsel  = bitsel;
        next_addr    = addr;
        next_acc     = acc;
        next_flags   = flags;
        next_cycles  = cycles;
        next_skip    = skip;
        next_done    = 1'b0;
        mem_we       = 1'b0;
        mem_wa       = addr;
        mem_wd       = wmerge[7:0];
        case (state)
            eoa_pkg::st_idle: begin
                if (wr_commit) begin
                    case (wb_adr_i)
                        `EOA_OFF_CMD: begin
                            next_op      = eoa_pkg::eoa_op_t'(wmerge[`EOA_CMD_OP_MSB:0]);
                            next_bitsel  = wmerge[`EOA_CMD_BIT_MSB:`EOA_CMD_BIT_LSB];
                            next_op_addr = addr;
                            next_cycles  = `EOA_CYC_RST;
                            next_skip    = 1'b0;
                            next_state   = eoa_pkg::st_fetch;
                        end
                        `EOA_OFF_ADDR:   next_addr  = wmerge[10:0];
                        `EOA_OFF_ACC:    next_acc   = wmerge[7:0];
                        `EOA_OFF_FLAGS:  next_flags = eoa_pkg::eoa_flags_t'(wmerge[5:0]);
                        `EOA_OFF_MEMDAT: mem_we     = 1'b1;
                        default: mem_we = 1'b0;
                    endcase
                end
            end
            eoa_pkg::st_fetch: begin
                // Operand address word cycle
                next_cycles = cycles + 2'h1;
                next_state  = eoa_pkg::st_exec;
            end
            eoa_pkg::st_exec: begin
                next_cycles = cycles + 2'h1;
                next_flags  = alu.flags;
                next_skip   = alu.skip;
                if (alu.wr_acc) begin
                    next_acc = alu.res;
                end
                mem_we = alu.wr_mem;
                mem_wa = op_addr;
                mem_wd = alu.res;
                if (alu.skip) begin
                    next_state = eoa_pkg::st_dummy;
                end else begin
                    next_state = eoa_pkg::st_idle;
                    next_done  = 1'b1;
                end
            end
            eoa_pkg::st_dummy: begin
                // Dummy slot stands in for the skipped instruction
                next_cycles = cycles + 2'h1;
                next_state  = eoa_pkg::st_idle;
                next_done   = 1'b1;
            end
            default: next_state = eoa_pkg::st_idle;
        endcase
        next_busy = (next_state != eoa_pkg::st_idle);
    end

    // Register stage, synchronous reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state   <= eoa_pkg::st_idle;
            op      <= eoa_pkg::decimal_adjust_to_mem;
            op_addr <= `EOA_ADDR_RST;
            bitsel  <= 3'h0;
            addr    <= `EOA_ADDR_RST;
            acc     <= `EOA_ACC_RST;
            flags   <= `EOA_FLAGS_RST;
            cycles  <= `EOA_CYC_RST;
            skip    <= 1'b0;
            done    <= 1'b0;
            busy    <= 1'b0;
            ack     <= 1'b0;
            dat     <= `EOA_RD_ZERO;
        end else begin
            state   <= next_state;
            op      <= next_op;
            op_addr <= next_op_addr;
            bitsel  <= next_bitsel;
            addr    <= next_addr;
            acc     <= next_acc;
            flags   <= next_flags;
            cycles  <= next_cycles;
            skip    <= next_skip;
            done    <= next_done;
            busy    <= next_busy;
            ack     <= next_ack;
            dat     <= next_dat;
        end
    end

    // Memory has no reset; contents are software's to initialise
    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_fetch_exec;
        start |=> busy ##1 (state == eoa_pkg::st_exec);
    endproperty
    a_fetch_exec: assert property (p_fetch_exec)
        else $error("operand fetch did not lead to execute");

    property p_two_cycles;
        (state == eoa_pkg::st_exec && !alu.skip)
            |=> (state == eoa_pkg::st_idle && cycles == `EOA_CYC_PLAIN && done);
    endproperty
    a_two_cycles: assert property (p_two_cycles)
        else $error("plain instruction not done in two cycles");

    property p_three_cycles;
        (state == eoa_pkg::st_exec && alu.skip) |=> !done ##1
            (state == eoa_pkg::st_idle && cycles == `EOA_CYC_SKIP && done && skip);
    endproperty
    a_three_cycles: assert property (p_three_cycles)
        else $error("taken skip not done in three cycles");

    property p_move_flags;
        (state == eoa_pkg::st_exec
            && (op == eoa_pkg::ext_move || op == eoa_pkg::ext_move_to_mem))
            |=> $stable(flags);
    endproperty
    a_move_flags: assert property (p_move_flags)
        else $error("move changed a flag");

    property p_rot_acc;
        (state == eoa_pkg::st_exec && op == eoa_pkg::ext_rotate_left_to_acc)
            |=> (acc == {$past(mem_rd[6:0]), $past(mem_rd[7])}
                 && mem[$past(op_addr)] == $past(mem_rd));
    endproperty
    a_rot_acc: assert property (p_rot_acc)
        else $error("rotate to acc wrong or memory touched");

    property p_sbc_carry;
        (state == eoa_pkg::st_exec && op == eoa_pkg::ext_sub_borrow_to_acc)
            |=> (flags.c == ({1'b0, $past(acc)} >= $past(sbc_need)));
    endproperty
    a_sbc_carry: assert property (p_sbc_carry)
        else $error("subtract with borrow carry wrong");

    property p_set_mem;
        (state == eoa_pkg::st_exec && op == eoa_pkg::ext_set_mem)
            |=> (mem[$past(op_addr)] == `EOA_BYTE_ONES && $stable(flags));
    endproperty
    a_set_mem: assert property (p_set_mem)
        else $error("byte set did not write all ones");

    property p_inc_skip;
        (state == eoa_pkg::st_exec && op == eoa_pkg::ext_inc_skip_zero)
            |-> (alu.skip == (mem_rd == `EOA_BYTE_ONES))
            ##1 (mem[$past(op_addr)] == $past(mem_rd) + `EOA_BYTE_ONE);
    endproperty
    a_inc_skip: assert property (p_inc_skip)
        else $error("increment skip wrong");

    property p_daa_flags;
        (state == eoa_pkg::st_exec && op == eoa_pkg::decimal_adjust_to_mem)
            |=> ((flags | 6'h01) == ($past(flags) | 6'h01));
    endproperty
    a_daa_flags: assert property (p_daa_flags)
        else $error("decimal adjust changed a flag besides carry");
endmodule

// file: verif/tb_eoa_top.sv
`timescale 1ns/1ps
module tb_eoa_top;
    logic        clk_i    = 1'b0;
    logic        rst_i    = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [3:0]  wb_sel_i = 4'hf;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        busy_o;
    logic        skip_o;
    logic        done_o;
    int          miscompares = 0;
    int          checks      = 0;
    logic [31:0] q;
    logic [3:0]  sel_mask = 4'hf;

    eoa_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o), .skip_o(skip_o),
        .done_o(done_o));

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    task automatic report_and_stop();
        if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Classic single cycle; the bound stands in for a hung slave
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                      output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= sel_mask;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
        @(posedge clk_i);
    endtask

    // Reference behaviour of one instruction
    function automatic void model(input logic [4:0] op, input logic [2:0] b,
        inout logic [7:0] a, inout logic [7:0] m, inout logic [5:0] f, output logic sk);
        logic [8:0] d;
        logic [4:0] ln;
        logic [7:0] r;
        sk = 1'b0;
        r  = 8'h00;
        case (op)
            5'h00: begin
                if (a[3:0] > 4'h9 || f[1]) r[3:0] = 4'h6;
                if (a[7:4] > 4'h9 || f[0]) r[7:4] = 4'h6;
                d = {1'b0, a} + {1'b0, r};
                m = d[7:0];
                f[0] = f[0] | d[8];
            end
            5'h01: begin m = m - 8'h01; f[2] = (m == 8'h00); end
            5'h02: begin a = m - 8'h01; f[2] = (a == 8'h00); end
            5'h03: begin m = m + 8'h01; f[2] = (m == 8'h00); end
            5'h04: begin a = m + 8'h01; f[2] = (a == 8'h00); end
            5'h05: a = m;
            5'h06: m = a;
            5'h07: begin a = a | m; f[2] = (a == 8'h00); end
            5'h08: begin m = a | m; f[2] = (m == 8'h00); end
            5'h09: m = {m[6:0], m[7]};
            5'h0a: a = {m[6:0], m[7]};
            5'h0b: begin r = {m[6:0], f[0]}; f[0] = m[7]; m = r; end
            5'h0c: begin a = {m[6:0], f[0]}; f[0] = m[7]; end
            5'h0d: m = {m[0], m[7:1]};
            5'h0e: a = {m[0], m[7:1]};
            5'h0f: begin r = {f[0], m[7:1]}; f[0] = m[0]; m = r; end
            5'h10: begin a = {f[0], m[7:1]}; f[0] = m[0]; end
            5'h11, 5'h12: begin
                d  = {1'b0, a} - {1'b0, m} - {8'h00, ~f[0]};
                ln = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~f[0]};
                r  = d[7:0];
                f[3] = (a[7] != m[7]) && (r[7] != a[7]);
                f[0] = ~d[8];
                f[1] = ~ln[4];
                f[2] = (r == 8'h00);
                f[4] = r[7] ^ f[3];
                f[5] = f[2] & f[5];
                if (op == 5'h11) a = r;
                else m = r;
            end
            5'h13: begin m = m - 8'h01; sk = (m == 8'h00); end
            5'h14: begin a = m - 8'h01; sk = (a == 8'h00); end
            5'h15: m = 8'hff;
            5'h16: m[b] = 1'b1;
            5'h17: begin m = m + 8'h01; sk = (m == 8'h00); end
            5'h18: begin a = m + 8'h01; sk = (a == 8'h00); end
            5'h19: sk = (m != 8'h00);
            5'h1a: sk = m[b];
            default: ;
        endcase
    endfunction

    // Load operands, start, time the instruction and read every result back
    task automatic exec(input logic [4:0] op, input logic [10:0] ad, input logic [7:0] a,
                        input logic [7:0] m, input logic [2:0] b, input logic [5:0] f);
        logic [7:0] ea;
        logic [7:0] em;
        logic [5:0] ef;
        logic       sk;
        int         n;
        ea = a;
        em = m;
        ef = f;
        model(op, b, ea, em, ef, sk);
        wb(1'b1, 8'h04, {21'h0, ad}, q);
        wb(1'b1, 8'h10, {24'h0, m}, q);
        wb(1'b1, 8'h08, {24'h0, a}, q);
        wb(1'b1, 8'h0c, {26'h0, f}, q);
        wb(1'b1, 8'h00, {21'h0, b, 3'h0, op}, q);
        check("busy", {31'h0, busy_o}, 32'h0000_0001);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (done_o !== 1'b1 && n < 10);
        check("cycles", n, sk ? 3 : 2);
        check("idle", {31'h0, busy_o}, 32'h0000_0000);
        // A missing done pulse ends the run rather than cascading
        if (n >= 10) begin
            report_and_stop();
        end
        check("skip_o", {31'h0, skip_o}, {31'h0, sk});
        wb(1'b0, 8'h14, 32'h0000_0000, q);
        check("info", q, {28'h0, sk ? 2'h3 : 2'h2, sk, 1'b0});
        wb(1'b0, 8'h08, 32'h0000_0000, q);
        check("acc", q, {24'h0, ea});
        wb(1'b0, 8'h0c, 32'h0000_0000, q);
        check("flags", q, {26'h0, ef});
        wb(1'b0, 8'h10, 32'h0000_0000, q);
        check("mem", q, {24'h0, em});
    endtask

    // Reset, register defaults, unmapped place, corner table, then random mix
    initial begin
        void'($urandom(32'h0000_d5e9));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 8'h08, 32'h0000_0000, q);
        check("acc_rst", q, 32'h0000_0000);
        // No lane selected: the write must leave the accumulator as it was
        sel_mask = 4'h0;
        wb(1'b1, 8'h08, 32'hffff_ffff, q);
        sel_mask = 4'hf;
        wb(1'b0, 8'h08, 32'h0000_0000, q);
        check("acc_lanes", q, 32'h0000_0000);
        wb(1'b0, 8'h14, 32'h0000_0000, q);
        check("info_rst", q, 32'h0000_0000);
        wb(1'b1, 8'h18, 32'hffff_ffff, q);
        wb(1'b0, 8'h18, 32'h0000_0000, q);
        check("unmapped", q, 32'h0000_0000);
        for (int op = 0; op < 32; op++) begin
            exec(op[4:0], 11'h7ff, 8'h00, 8'h00, 3'h0, 6'h3f);
            exec(op[4:0], 11'h000, 8'h9a, 8'h01, 3'h0, 6'h00);
            exec(op[4:0], 11'h400, 8'h80, 8'hff, 3'h7, 6'h01);
        end
        for (int i = 0; i < 60; i++) begin
            exec(5'($urandom_range(31, 0)), 11'($urandom), 8'($urandom), 8'($urandom),
                 3'($urandom), 6'($urandom));
        end
        report_and_stop();
    end
endmodule
